//--- sim/tb.sv
// Purpose: Self-checking bench for the banked data address generator.
// Assumes: APB master driven on rising edges; one clock, async reset.
// Notes:   Expectations come from the address map rules, not the design.
`timescale 1ns/10ps
`include "bank_addr_cfg.svh"
module tb;
  import bank_addr_pkg::*;
  // ==========================================================
  // Signals
  logic        pclk, presetn, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_val;
  logic        pready, pslverr, err_val;
  logic [11:0] data_addr;
  logic        data_valid, data_write_en, data_zero;
  int          bad_count, checks_done;
  logic [7:0]  win_op  [4] = '{8'h00, 8'h7f, 8'h80, 8'hff};
  logic [11:0] win_exp [4] = '{12'h000, 12'h07f, 12'hf80, 12'hfff};

  banked_data_address_gen dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .data_addr(data_addr), .data_valid(data_valid), .data_write_en(data_write_en),
    .data_zero(data_zero));

  // Clock, 5 ns period
  always #2.5 pclk = ~pclk;

  // ==========================================================
  // Tasks
  task automatic summarize();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : summarize

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; idle cycle after it so psel is never driven twice at one edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      bad_count++;
      $display("[ERR] pready expected 1 seen none");
      summarize();
    end
    rd_val  = prdata;
    err_val = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string nm);
    apb(1'b0, a, 32'h0);
    chk(nm, rd_val, exp);
  endtask : rdc

  // Direct request: access bit selects banked (1) or window (0)
  task automatic direct(input logic acc, input logic w, input logic [7:0] op);
    apb(1'b1, `OFS_DIRECT_REQ, {21'h0, 1'b0, w, acc, op});
  endtask : direct

  // ==========================================================
  // Main sequence
  initial begin
    pclk = 0; presetn = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = '0; pwdata = '0; bad_count = 0; checks_done = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`OFS_BANK_SELECT, 32'h0, "bank_select reset");
    rdc(`OFS_BANK_IMPL, 32'h0000ffff, "bank_impl reset");
    apb(1'b1, `OFS_BANK_SELECT, 32'hffff_ffa5);
    rdc(`OFS_BANK_SELECT, 32'h5, "bank_select upper");
    $display("test registers done");
    // Every bank, lowest and highest offset alternately
    for (int b = 0; b < 16; b++) begin
      apb(1'b1, `OFS_BANK_SELECT, 32'(b));
      direct(1'b1, 1'b0, b[0] ? 8'hff : 8'h00);
      chk("data_addr bank", 32'(data_addr), {20'h0, 4'(b), b[0] ? 8'hff : 8'h00});
    end
    $display("test banks done");
    // Window ignores bank select; boundary offsets on both halves
    apb(1'b1, `OFS_BANK_SELECT, 32'h5);
    for (int i = 0; i < 4; i++) begin
      direct(1'b0, 1'b0, win_op[i]);
      chk("data_addr window", 32'(data_addr), 32'(win_exp[i]));
    end
    rdc(`OFS_RESULT, 32'hfff, "result");
    rdc(`OFS_STATUS, 32'h1, "status read");
    $display("test window done");
    // Literal bank load, then an access to an unimplemented bank
    apb(1'b1, `OFS_DIRECT_REQ, 32'h0000_040c);
    rdc(`OFS_BANK_SELECT, 32'hc, "bank_select load");
    apb(1'b1, `OFS_BANK_IMPL, 32'h0000_efff);
    direct(1'b1, 1'b1, 8'h34);
    chk("data_addr absent", 32'(data_addr), 32'hc34);
    chk("write_en absent", 32'(data_write_en), 32'h0);
    chk("zero absent", 32'(data_zero), 32'h1);
    chk("valid absent", 32'(data_valid), 32'h0);
    direct(1'b0, 1'b1, 8'h10);
    rdc(`OFS_STATUS, 32'h3, "status write");
    $display("test unimplemented done");
    // File to file move leaves bank select and address outputs alone
    apb(1'b1, `OFS_MOVE_REQ, 32'h0abc_0123);
    rdc(`OFS_MOVE_REQ, 32'h0abc_0123, "move");
    rdc(`OFS_BANK_SELECT, 32'hc, "bank_select move");
    chk("data_addr move", 32'(data_addr), 32'h010);
    // Read-only write ignored, unmapped address refused
    apb(1'b1, `OFS_RESULT, 32'hffff_ffff);
    rdc(`OFS_RESULT, 32'h010, "result ro");
    apb(1'b0, 12'h018, 32'h0);
    chk("pslverr", 32'(err_val), 32'h1);
    $display("test move and errors done");
    summarize();
  end
endmodule : tb

//--- src/bank_addr_cfg.svh
// Purpose: Constants for the banked data address generator.
// Assumes: 12-bit data space, 16 banks of 256 locations.
// Notes:   Offsets are byte addresses on the APB register bus.
`ifndef BANK_ADDR_CFG_SVH
`define BANK_ADDR_CFG_SVH
// ==========================================================
// Register map
`define OFS_BANK_SELECT   12'h000
`define OFS_BANK_IMPL     12'h004
`define OFS_DIRECT_REQ    12'h008
`define OFS_MOVE_REQ      12'h00c
`define OFS_RESULT        12'h010
`define OFS_STATUS        12'h014
// ==========================================================
// Field positions and values
`define BANK_LO_BIT       0
`define BANK_LO_W         4
`define WIN_LOW_TOP       8'h7f
`define WIN_HIGH_BANK     4'hf
`define WIN_LOW_BANK      4'h0
`define RST_BANK_SELECT   4'h0
`define RST_BANK_IMPL     16'hffff
// Direct request fields: [7:0] operand, [8] access bit, [9] write, [10] bank load
`define DRQ_ACCESS_BIT    8
`define DRQ_WRITE_BIT     9
`define DRQ_BANK_LOAD_BIT 10
// Move request fields: [11:0] source, [27:16] destination
`define MRQ_DST_LSB       16
`endif

//--- src/bank_addr_pkg.sv
// Purpose: Types for the banked data address generator.
// Assumes: Included constants header.
// Notes:   State is one packed struct.
package bank_addr_pkg;
  // ========================================================
  // Register state
  typedef struct packed {
    logic [3:0]  bank_sel;      // Low bank select bits
    logic [15:0] bank_impl;     // One bit per implemented bank
    logic [11:0] addr;          // Last generated data address
    logic        addr_valid;    // Address points to real memory
    logic        addr_write;    // Last access was a write to a present bank
    logic        zero_data;     // Read data forced to zero
    logic [11:0] move_src;      // File to file source
    logic [11:0] move_dst;      // File to file destination
    logic        pready;
    logic [31:0] prdata;
    logic        pslverr;
  } state_t;
endpackage : bank_addr_pkg

//--- src/banked_data_address_gen.sv
// Purpose: Data address generation for a banked 4096-location data space.
// Assumes: APB slave on pclk; one-cycle answer (pready one cycle after setup).
// Notes:   Address results are registered and readable; no memory is held here.
//
// Function
// - Quick window is bank 15 upper 128 plus bank 0 lower 128.
// - Access bit chooses bank select register or quick window.
// - With access bit zero, window runs on from bank 0 into bank 15.
// - Upper window half reaches special function registers without banking.
// - Data memory is split into sixteen selectable banks.
// - Each bank spans offsets 00h to FFh, 256 locations.
// - Upper four address bits come from bank select low nibble.
// - Bank select upper nibble reads zero, writes discarded.
// - Unimplemented bank reads zero and drops writes.
// - Flags still update from the zero data of unimplemented bank.
// - File to file move ignores bank select, uses full 12-bit addresses.
// - Move literal to bank instruction writes bank select register.
//
// Chosen here: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "bank_addr_cfg.svh"
module banked_data_address_gen
  import bank_addr_pkg::*;
#(
  parameter int NUM_BANKS = 16,           // Selectable banks
  parameter int BANK_SIZE = 256            // Locations per bank
) (
  input  wire logic        pclk,           // Core clock, 200 MHz
  input  wire logic        presetn,        // Async reset, active low
  input  wire logic        psel,           // APB select
  input  wire logic        penable,        // APB enable
  input  wire logic        pwrite,         // APB direction
  input  wire logic [11:0] paddr,          // APB byte address
  input  wire logic [31:0] pwdata,         // APB write data
  output logic             pready,         // APB ready
  output logic [31:0]      prdata,         // APB read data
  output logic             pslverr,        // APB error, unmapped address
  output logic [11:0]      data_addr,      // Generated data address
  output logic             data_valid,     // Address reaches real memory
  output logic             data_write_en,  // Write allowed to memory
  output logic             data_zero       // Read data forced to zero for flags
);
  // ========================================================
  // Elaboration checks: the nibble and byte split below only serves 16 x 256
  if (NUM_BANKS != 16 || BANK_SIZE != 256) begin : g_bad_geometry
    $error("Bank geometry must be 16 banks of 256");
  end

  state_t cur_ff, nxt_cur;

  logic        setup;
  logic        acc;
  logic [7:0]  opnd;
  logic [11:0] win_addr;
  logic [11:0] bnk_addr;
  logic [11:0] gen_addr;
  logic [3:0]  gen_bank;
  logic        impl_hit;

  // ========================================================
  // Address formation for a direct request
  always_comb begin
    opnd     = pwdata[7:0];
    acc      = pwdata[`DRQ_ACCESS_BIT];
    // Window folds offsets above 7F onto the special function half
    win_addr = (opnd <= `WIN_LOW_TOP) ? {`WIN_LOW_BANK, opnd}
                                      : {`WIN_HIGH_BANK, opnd};
    bnk_addr = {cur_ff.bank_sel, opnd};
    gen_addr = acc ? bnk_addr : win_addr;
    gen_bank = gen_addr[11:8];
    impl_hit = cur_ff.bank_impl[gen_bank];
  end

  assign setup = psel && !penable;

  // ========================================================
  // Next state: APB slave, one wait-free access phase
  always_comb begin
    nxt_cur         = cur_ff;
    nxt_cur.pready  = 1'b0;
    nxt_cur.pslverr = 1'b0;
    nxt_cur.prdata  = 32'h0000_0000;
    if (setup) begin
      // Answer lands in the access phase; decode done in setup
      nxt_cur.pready = 1'b1;
      case (paddr)
        `OFS_BANK_SELECT: begin
          if (pwrite)
            nxt_cur.bank_sel = pwdata[3:0];
          nxt_cur.prdata = {28'h0000000, cur_ff.bank_sel};
        end
        `OFS_BANK_IMPL: begin
          if (pwrite)
            nxt_cur.bank_impl = pwdata[15:0];
          nxt_cur.prdata = {16'h0000, cur_ff.bank_impl};
        end
        `OFS_DIRECT_REQ: begin
          if (pwrite) begin
            if (pwdata[`DRQ_BANK_LOAD_BIT]) begin
              // Literal bank load; upper literal bits are dropped
              nxt_cur.bank_sel = pwdata[3:0];
            end else begin
              nxt_cur.addr       = gen_addr;
              nxt_cur.addr_valid = impl_hit;
              nxt_cur.addr_write = pwdata[`DRQ_WRITE_BIT] && impl_hit;
              nxt_cur.zero_data  = !impl_hit;
            end
          end
        end
        `OFS_MOVE_REQ: begin
          if (pwrite) begin
            // Move carries full addresses; bank select is not consulted
            nxt_cur.move_src = pwdata[11:0];
            nxt_cur.move_dst = pwdata[`MRQ_DST_LSB +: 12];
          end
          nxt_cur.prdata = {4'h0, cur_ff.move_dst, 4'h0, cur_ff.move_src};
        end
        `OFS_RESULT: begin
          nxt_cur.prdata = {20'h00000, cur_ff.addr};
        end
        `OFS_STATUS: begin
          nxt_cur.prdata = {29'h00000000, cur_ff.zero_data, cur_ff.addr_write, cur_ff.addr_valid};
        end
        default: begin
          nxt_cur.pslverr = 1'b1;
        end
      endcase
    end
  end

  // ========================================================
  // State register
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_ff            <= '0;
      cur_ff.bank_sel   <= `RST_BANK_SELECT;
      cur_ff.bank_impl  <= `RST_BANK_IMPL;
    end else begin
      cur_ff <= nxt_cur;
    end
  end

  assign pready        = cur_ff.pready;
  assign prdata        = cur_ff.prdata;
  assign pslverr       = cur_ff.pslverr;
  assign data_addr     = cur_ff.addr;
  assign data_valid    = cur_ff.addr_valid;
  assign data_write_en = cur_ff.addr_write;
  assign data_zero     = cur_ff.zero_data;

  // ========================================================
  // Checks
  logic dreq;
  assign dreq = setup && pwrite && paddr == `OFS_DIRECT_REQ && !pwdata[`DRQ_BANK_LOAD_BIT];

  property p_win_low;
    @(posedge pclk) disable iff (!presetn)
      dreq && !pwdata[`DRQ_ACCESS_BIT] && pwdata[7] == 1'b0 |=> data_addr[11:8] == 4'h0;
  endproperty
  a_win_low: assert property (p_win_low) else $error("Window low half wrong");

  property p_win_high;
    @(posedge pclk) disable iff (!presetn)
      dreq && !pwdata[`DRQ_ACCESS_BIT] && pwdata[7] |=> data_addr[11:8] == 4'hf;
  endproperty
  a_win_high: assert property (p_win_high) else $error("Window high half wrong");

  property p_banked;
    @(posedge pclk) disable iff (!presetn)
      dreq && pwdata[`DRQ_ACCESS_BIT] |=> data_addr == {$past(cur_ff.bank_sel), $past(pwdata[7:0])};
  endproperty
  a_banked: assert property (p_banked) else $error("Banked address wrong");

  property p_bank_sel_upper;
    @(posedge pclk) disable iff (!presetn)
      pready && $past(paddr) == `OFS_BANK_SELECT |-> prdata[31:4] == 28'h0000000;
  endproperty
  a_bank_sel_upper: assert property (p_bank_sel_upper) else $error("Bank select upper bits not zero");

  property p_unimpl;
    @(posedge pclk) disable iff (!presetn)
      data_zero |-> !data_write_en && !data_valid;
  endproperty
  a_unimpl: assert property (p_unimpl) else $error("Unimplemented bank accessed");

  property p_zero_flag;
    @(posedge pclk) disable iff (!presetn)
      dreq && !impl_hit |=> data_zero;
  endproperty
  a_zero_flag: assert property (p_zero_flag) else $error("Zero data not flagged");

  property p_move;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && paddr == `OFS_MOVE_REQ |=> cur_ff.move_src == $past(pwdata[11:0]) &&
        $stable(cur_ff.bank_sel);
  endproperty
  a_move: assert property (p_move) else $error("Move used bank select");

  property p_bank_load;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && paddr == `OFS_DIRECT_REQ && pwdata[`DRQ_BANK_LOAD_BIT]
        |=> cur_ff.bank_sel == $past(pwdata[3:0]);
  endproperty
  a_bank_load: assert property (p_bank_load) else $error("Literal bank load failed");

  property p_ready;
    @(posedge pclk) disable iff (!presetn)
      setup |=> pready ##1 !pready;
  endproperty
  a_ready: assert property (p_ready) else $error("APB ready timing wrong");

  // ========================================================
  // Further checks: window seam, outcome flags, error response, holding
  // Mapped offsets decoded apart from the case, so a slip in either one shows up
  logic mapped_addr;
  assign mapped_addr = paddr == `OFS_BANK_SELECT || paddr == `OFS_BANK_IMPL ||
                       paddr == `OFS_DIRECT_REQ  || paddr == `OFS_MOVE_REQ  ||
                       paddr == `OFS_RESULT      || paddr == `OFS_STATUS;

  // Last low-half window location
  property p_win_seam_lo;
    @(posedge pclk) disable iff (!presetn)
      dreq && !pwdata[`DRQ_ACCESS_BIT] && pwdata[7:0] == 8'h7f |=> data_addr == 12'h07f;
  endproperty
  a_win_seam_lo: assert property (p_win_seam_lo) else $error("Window low seam wrong");

  // Next window offset lands on the first special function location
  property p_win_seam_hi;
    @(posedge pclk) disable iff (!presetn)
      dreq && !pwdata[`DRQ_ACCESS_BIT] && pwdata[7:0] == 8'h80 |=> data_addr == 12'hf80;
  endproperty
  a_win_seam_hi: assert property (p_win_seam_hi) else $error("Window high seam wrong");

  // Window keeps the operand as the low address byte
  property p_win_offset;
    @(posedge pclk) disable iff (!presetn)
      dreq && !pwdata[`DRQ_ACCESS_BIT] |=> data_addr[7:0] == $past(pwdata[7:0]);
  endproperty
  a_win_offset: assert property (p_win_offset) else $error("Window offset wrong");

  // A present bank gives a real address and clears the zero flag
  property p_impl_valid;
    @(posedge pclk) disable iff (!presetn)
      dreq && impl_hit |=> data_valid && !data_zero;
  endproperty
  a_impl_valid: assert property (p_impl_valid) else $error("Present bank not valid");

  // A write to a present bank must reach memory
  property p_impl_write;
    @(posedge pclk) disable iff (!presetn)
      dreq && impl_hit && pwdata[`DRQ_WRITE_BIT] |=> data_write_en;
  endproperty
  a_impl_write: assert property (p_impl_write) else $error("Write to present bank lost");

  // An absent bank never sees a write strobe
  property p_absent_drop;
    @(posedge pclk) disable iff (!presetn)
      dreq && !impl_hit |=> !data_write_en && !data_valid;
  endproperty
  a_absent_drop: assert property (p_absent_drop) else $error("Absent bank not dropped");

  // Literal bank load only moves bank select, never the last address
  property p_load_keeps;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && paddr == `OFS_DIRECT_REQ && pwdata[`DRQ_BANK_LOAD_BIT]
        |=> $stable(data_addr) && $stable(data_zero);
  endproperty
  a_load_keeps: assert property (p_load_keeps) else $error("Bank load changed address");

  // Move keeps its full destination and leaves the direct result alone
  property p_move_dst;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && paddr == `OFS_MOVE_REQ
        |=> cur_ff.move_dst == $past(pwdata[`MRQ_DST_LSB +: 12]) && $stable(data_addr);
  endproperty
  a_move_dst: assert property (p_move_dst) else $error("Move destination wrong");

  // Readback shows the bank nibble as it stood at setup
  property p_bank_read;
    @(posedge pclk) disable iff (!presetn)
      pready && $past(paddr) == `OFS_BANK_SELECT |-> prdata[3:0] == $past(cur_ff.bank_sel);
  endproperty
  a_bank_read: assert property (p_bank_read) else $error("Bank select readback wrong");

  // Only the low nibble of a bank select write is kept
  property p_bank_write;
    @(posedge pclk) disable iff (!presetn)
      setup && pwrite && paddr == `OFS_BANK_SELECT |=> cur_ff.bank_sel == $past(pwdata[3:0]);
  endproperty
  a_bank_write: assert property (p_bank_write) else $error("Bank select write wrong");

  // Unmapped offsets answer with an error in the access phase
  property p_err_resp;
    @(posedge pclk) disable iff (!presetn)
      setup && !mapped_addr |=> pready && pslverr;
  endproperty
  a_err_resp: assert property (p_err_resp) else $error("Unmapped offset not refused");

  // Mapped offsets never raise an error
  property p_ok_resp;
    @(posedge pclk) disable iff (!presetn)
      setup && mapped_addr |=> pready && !pslverr;
  endproperty
  a_ok_resp: assert property (p_ok_resp) else $error("Mapped offset refused");

  // Read data and error stay quiet outside the access phase
  property p_idle_quiet;
    @(posedge pclk) disable iff (!presetn)
      !pready |-> prdata == 32'h0000_0000 && !pslverr;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("Bus outputs not quiet when idle");

  // Address results stand until the next direct request
  property p_result_hold;
    @(posedge pclk) disable iff (!presetn)
      !dreq |=> $stable(data_addr) && $stable(data_zero);
  endproperty
  a_result_hold: assert property (p_result_hold) else $error("Address result did not hold");
endmodule : banked_data_address_gen
